// >>> common/pinmux_pkg.sv
// constants, register map and carrier types for the serial and timer pin multiplexer
package pinmux_pkg;
    typedef logic [7:0] byte_t;
    // one port's software settings travel together
    typedef struct packed {
        byte_t data;
        byte_t dir;
        byte_t pull;
        byte_t od;
    } port_cfg_s;
    localparam int PORTS = 4;
    localparam int SERS = 3;
    localparam logic [1:0] IDX_P0 = 2'h0;
    localparam logic [1:0] IDX_P1 = 2'h1;
    localparam logic [1:0] IDX_P5 = 2'h2;
    localparam logic [1:0] IDX_P7 = 2'h3;
    // register byte addresses; 0x00..0x3c is port block, four words per port
    localparam logic [7:0] ADR_OMD = 8'h40;
    localparam logic [7:0] ADR_SER0 = 8'h44;
    localparam logic [7:0] ADR_SER1 = 8'h48;
    localparam logic [7:0] ADR_SER3 = 8'h4c;
    localparam logic [7:0] ADR_I2C = 8'h50;
    localparam logic [7:0] ADR_RMT = 8'h54;
    localparam logic [7:0] ADR_TLOC = 8'h58;
    localparam logic [7:0] ADR_PIN_BASE = 8'h60;
    localparam logic [7:0] ADR_PIN_END = 8'h70;
    localparam logic [1:0] FLD_DATA = 2'h0;
    localparam logic [1:0] FLD_DIR = 2'h1;
    localparam logic [1:0] FLD_PULL = 2'h2;
    localparam logic [1:0] FLD_OD = 2'h3;
    // serial mode register bits
    localparam int MODE_TX = 0;
    localparam int MODE_RX = 1;
    localparam int MODE_CLK = 2;
    localparam int MODE_UART = 3;
    localparam int MODE_LOCB = 4;
    localparam int I2C_EN = 0;
    localparam int I2C_LOCB = 1;
    localparam int RMT_EN = 0;
    localparam int TLOC_T0B = 0;
    localparam int TLOC_T4B = 1;
    // serial pin locations: ser0 a/b, ser1 a/b, ser3
    localparam int LOC_PORT [5] = '{0, 3, 0, 3, 2};
    localparam int LOC_TX [5] = '{3, 0, 0, 3, 1};
    localparam int LOC_RX [5] = '{4, 1, 1, 4, 0};
    localparam int LOC_CLK [5] = '{5, 2, 2, 5, 2};
    // timer, i2c and remote pin bits
    localparam int T0A_BIT = 0;
    localparam int T0B_BIT = 1;
    localparam int T4A_BIT = 2;
    localparam int T4B_BIT = 3;
    localparam int T1_BIT = 6;
    localparam int T5_BIT = 7;
    localparam int I2C_DA_BIT = 1;
    localparam int I2C_DB_BIT = 3;
    localparam int I2C_CK_BIT = 4;
    localparam int RMT_BIT = 0;
    localparam byte_t REG_RST = 8'h00;
endpackage

// >>> core/serial_timer_pin_mux.sv
// pin multiplexer for serial, uart, i2c, timer and remote-carrier pins with wishbone registers
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - serial data and clock pins each choose push-pull or open-drain drive
// - transmit pin carries serial data only with output direction and transmit mode
// - receive pin feeds interface only with input direction and receive mode
// - serial clock pin direction follows port direction with interface mode
// - in uart mode the shared transmit pin carries uart transmit data
// - in uart mode the shared receive pin feeds the uart receiver
// - timer pins set as inputs deliver event clocks to their timers
// - timer pulse output needs port 1 special function and output direction
// - pull-up applies only to inputs whose pull-up bit is set
// - remote pin carries carrier only with special function, output and enable
// - pins without a selected peripheral behave as plain general-purpose pins
module serial_timer_pin_mux (
    input wire logic REF_CLK_IN,
    input wire logic RESET_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic [7:0] PORT0_PIN_IN,
    input wire logic [7:0] PORT1_PIN_IN,
    input wire logic [7:0] PORT5_PIN_IN,
    input wire logic [7:0] PORT7_PIN_IN,
    output logic [7:0] PORT0_PIN_OUT,
    output logic [7:0] PORT1_PIN_OUT,
    output logic [7:0] PORT5_PIN_OUT,
    output logic [7:0] PORT7_PIN_OUT,
    output logic [7:0] PORT0_PIN_OE_OUT,
    output logic [7:0] PORT1_PIN_OE_OUT,
    output logic [7:0] PORT5_PIN_OE_OUT,
    output logic [7:0] PORT7_PIN_OE_OUT,
    output logic [7:0] PORT0_PULLUP_OUT,
    output logic [7:0] PORT1_PULLUP_OUT,
    output logic [7:0] PORT5_PULLUP_OUT,
    output logic [7:0] PORT7_PULLUP_OUT,
    input wire logic [2:0] SER_TX_DATA_IN,
    input wire logic [2:0] SER_CLK_IN,
    output logic [2:0] SER_RX_DATA_OUT,
    output logic [2:0] SER_CLK_OUT,
    input wire logic [1:0] UART_TX_DATA_IN,
    output logic [1:0] UART_RX_DATA_OUT,
    input wire logic [3:0] TIMER_PULSE_IN,
    output logic [3:0] TIMER_EVENT_OUT,
    input wire logic REMOTE_CARRIER_IN,
    input wire logic I2C_DATA_DRV_IN,
    input wire logic I2C_CLOCK_DRV_IN,
    output logic I2C_DATA_OUT,
    output logic I2C_CLOCK_OUT
);

////////////////////////////////////////////////////////////////////////////////
// declarations

pinmux_pkg::port_cfg_s cfg_ff [pinmux_pkg::PORTS];
logic [7:0] omd_ff;
logic [7:0] mode_ff [pinmux_pkg::SERS];
logic [7:0] i2c_ff;
logic [7:0] rmt_ff;
logic [7:0] tloc_ff;
logic [7:0] pin_in [pinmux_pkg::PORTS];
logic [7:0] sync1_ff [pinmux_pkg::PORTS];
logic [7:0] sync_ff [pinmux_pkg::PORTS];
logic [7:0] psel [pinmux_pkg::PORTS];
logic [7:0] pval [pinmux_pkg::PORTS];
logic [7:0] drive [pinmux_pkg::PORTS];
logic [7:0] out_ff [pinmux_pkg::PORTS];
logic [7:0] oe_ff [pinmux_pkg::PORTS];
logic [7:0] pull_ff [pinmux_pkg::PORTS];
logic [2:0] nxt_rx;
logic [2:0] nxt_clk;
logic [1:0] nxt_urx;
logic [3:0] nxt_tev;
logic [2:0] rx_ff;
logic [2:0] clk_ff;
logic [1:0] urx_ff;
logic [3:0] tev_ff;
logic i2c_data_ff;
logic i2c_clock_ff;
logic ack_ff;
logic [31:0] dat_ff;
logic bus_req;
logic wr;
logic [1:0] wb_port;
logic [7:0] wb_byte;
logic [7:0] rd_data;

////////////////////////////////////////////////////////////////////////////////
// wishbone slave

// one request per cycle pair, ack drops after one cycle
assign bus_req = WB_CYC_IN & WB_STB_IN & ~ack_ff;
assign wr = bus_req & WB_WE_IN & WB_SEL_IN[0];
assign wb_port = WB_ADR_IN[5:4];
assign wb_byte = WB_DAT_IN[7:0];

// read mux, unmapped words read zero
always_comb begin
    rd_data = 8'h00;
    if (WB_ADR_IN < pinmux_pkg::ADR_OMD) begin
        case (WB_ADR_IN[3:2])
            pinmux_pkg::FLD_DATA: rd_data = cfg_ff[wb_port].data;
            pinmux_pkg::FLD_DIR: rd_data = cfg_ff[wb_port].dir;
            pinmux_pkg::FLD_PULL: rd_data = cfg_ff[wb_port].pull;
            default: rd_data = cfg_ff[wb_port].od;
        endcase
    end else if (WB_ADR_IN >= pinmux_pkg::ADR_PIN_BASE && WB_ADR_IN < pinmux_pkg::ADR_PIN_END) begin
        rd_data = sync_ff[WB_ADR_IN[3:2]]; // synchronised pin levels
    end else begin
        case (WB_ADR_IN)
            pinmux_pkg::ADR_OMD: rd_data = omd_ff;
            pinmux_pkg::ADR_SER0: rd_data = mode_ff[0];
            pinmux_pkg::ADR_SER1: rd_data = mode_ff[1];
            pinmux_pkg::ADR_SER3: rd_data = mode_ff[2];
            pinmux_pkg::ADR_I2C: rd_data = i2c_ff;
            pinmux_pkg::ADR_RMT: rd_data = rmt_ff;
            pinmux_pkg::ADR_TLOC: rd_data = tloc_ff;
            default: rd_data = 8'h00;
        endcase
    end
end

// ack and registered read data
always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
        ack_ff <= 1'b0;
        dat_ff <= 32'h00000000;
    end else begin
        ack_ff <= bus_req;
        if (bus_req) begin
            dat_ff <= {24'h000000, rd_data};
        end
    end
end

// port data, direction, pull-up and drive-type registers
always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
        for (int p = 0; p < pinmux_pkg::PORTS; p++) begin
            cfg_ff[p] <= '0;
        end
    end else if (wr && WB_ADR_IN < pinmux_pkg::ADR_OMD) begin
        case (WB_ADR_IN[3:2])
            pinmux_pkg::FLD_DATA: cfg_ff[wb_port].data <= wb_byte;
            pinmux_pkg::FLD_DIR: cfg_ff[wb_port].dir <= wb_byte;
            pinmux_pkg::FLD_PULL: cfg_ff[wb_port].pull <= wb_byte;
            default: cfg_ff[wb_port].od <= wb_byte;
        endcase
    end
end

// peripheral mode and selection registers
always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
        omd_ff <= pinmux_pkg::REG_RST;
        for (int s = 0; s < pinmux_pkg::SERS; s++) begin
            mode_ff[s] <= pinmux_pkg::REG_RST;
        end
        i2c_ff <= pinmux_pkg::REG_RST;
        rmt_ff <= pinmux_pkg::REG_RST;
        tloc_ff <= pinmux_pkg::REG_RST;
    end else if (wr) begin
        case (WB_ADR_IN)
            pinmux_pkg::ADR_OMD: omd_ff <= wb_byte;
            pinmux_pkg::ADR_SER0: mode_ff[0] <= wb_byte;
            pinmux_pkg::ADR_SER1: mode_ff[1] <= wb_byte;
            pinmux_pkg::ADR_SER3: mode_ff[2] <= wb_byte;
            pinmux_pkg::ADR_I2C: i2c_ff <= wb_byte;
            pinmux_pkg::ADR_RMT: rmt_ff <= wb_byte;
            pinmux_pkg::ADR_TLOC: tloc_ff <= wb_byte;
            default: ;
        endcase
    end
end

assign WB_ACK_OUT = ack_ff;
assign WB_DAT_OUT = dat_ff;

////////////////////////////////////////////////////////////////////////////////
// pin input synchronisers

assign pin_in[0] = PORT0_PIN_IN;
assign pin_in[1] = PORT1_PIN_IN;
assign pin_in[2] = PORT5_PIN_IN;
assign pin_in[3] = PORT7_PIN_IN;

// two flops before any logic looks at a pin
always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
        for (int p = 0; p < pinmux_pkg::PORTS; p++) begin
            sync1_ff[p] <= 8'h00;
            sync_ff[p] <= 8'h00;
        end
    end else begin
        for (int p = 0; p < pinmux_pkg::PORTS; p++) begin
            sync1_ff[p] <= pin_in[p];
            sync_ff[p] <= sync1_ff[p];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// function routing

// selects peripheral drive per pin and gates pin levels into peripherals
always_comb begin
    int k;
    int pp;
    int tb;
    k = 0;
    pp = 0;
    tb = 0;
    for (int p = 0; p < pinmux_pkg::PORTS; p++) begin
        psel[p] = 8'h00;
        pval[p] = 8'h00;
    end
    nxt_rx = 3'b111;
    nxt_clk = 3'b111;
    nxt_urx = 2'b11;
    nxt_tev = 4'h0;
    for (int s = 0; s < pinmux_pkg::SERS; s++) begin
        k = 2 * s + ((s < 2 && mode_ff[s][pinmux_pkg::MODE_LOCB]) ? 1 : 0);
        pp = pinmux_pkg::LOC_PORT[k];
        // transmit data, uart or clocked serial
        if (mode_ff[s][pinmux_pkg::MODE_TX]) begin
            psel[pp][pinmux_pkg::LOC_TX[k]] = 1'b1;
            if (s < 2 && mode_ff[s][pinmux_pkg::MODE_UART]) begin
                pval[pp][pinmux_pkg::LOC_TX[k]] = UART_TX_DATA_IN[s == 1];
            end else begin
                pval[pp][pinmux_pkg::LOC_TX[k]] = SER_TX_DATA_IN[s];
            end
        end
        // received data only while the pin is an input
        if (mode_ff[s][pinmux_pkg::MODE_RX] && !cfg_ff[pp].dir[pinmux_pkg::LOC_RX[k]]) begin
            if (s < 2 && mode_ff[s][pinmux_pkg::MODE_UART]) begin
                nxt_urx[s == 1] = sync_ff[pp][pinmux_pkg::LOC_RX[k]];
            end else begin
                nxt_rx[s] = sync_ff[pp][pinmux_pkg::LOC_RX[k]];
            end
        end
        // clock pin: driven in master mode, sampled when an input
        if (mode_ff[s][pinmux_pkg::MODE_TX] || mode_ff[s][pinmux_pkg::MODE_RX]) begin
            if (mode_ff[s][pinmux_pkg::MODE_CLK]) begin
                psel[pp][pinmux_pkg::LOC_CLK[k]] = 1'b1;
                pval[pp][pinmux_pkg::LOC_CLK[k]] = SER_CLK_IN[s];
            end
            if (!cfg_ff[pp].dir[pinmux_pkg::LOC_CLK[k]]) begin
                nxt_clk[s] = sync_ff[pp][pinmux_pkg::LOC_CLK[k]];
            end
        end
    end
    // i2c pins; open-drain and output direction are set by software
    if (i2c_ff[pinmux_pkg::I2C_EN]) begin
        if (i2c_ff[pinmux_pkg::I2C_LOCB]) begin
            psel[pinmux_pkg::IDX_P5][pinmux_pkg::I2C_DB_BIT] = 1'b1;
            pval[pinmux_pkg::IDX_P5][pinmux_pkg::I2C_DB_BIT] = I2C_DATA_DRV_IN;
        end else begin
            psel[pinmux_pkg::IDX_P0][pinmux_pkg::I2C_DA_BIT] = 1'b1;
            pval[pinmux_pkg::IDX_P0][pinmux_pkg::I2C_DA_BIT] = I2C_DATA_DRV_IN;
        end
        psel[pinmux_pkg::IDX_P5][pinmux_pkg::I2C_CK_BIT] = 1'b1;
        pval[pinmux_pkg::IDX_P5][pinmux_pkg::I2C_CK_BIT] = I2C_CLOCK_DRV_IN;
    end
    // port 1 special function: remote carrier over timer 0 pulse
    if (omd_ff[pinmux_pkg::RMT_BIT]) begin
        psel[pinmux_pkg::IDX_P1][pinmux_pkg::RMT_BIT] = 1'b1;
        if (rmt_ff[pinmux_pkg::RMT_EN]) begin
            pval[pinmux_pkg::IDX_P1][pinmux_pkg::RMT_BIT] = REMOTE_CARRIER_IN;
        end else begin
            pval[pinmux_pkg::IDX_P1][pinmux_pkg::RMT_BIT] = TIMER_PULSE_IN[0];
        end
    end
    if (omd_ff[pinmux_pkg::T4A_BIT]) begin
        psel[pinmux_pkg::IDX_P1][pinmux_pkg::T4A_BIT] = 1'b1;
        pval[pinmux_pkg::IDX_P1][pinmux_pkg::T4A_BIT] = TIMER_PULSE_IN[2];
    end
    // timer event clocks from input pins
    tb = tloc_ff[pinmux_pkg::TLOC_T0B] ? pinmux_pkg::T0B_BIT : pinmux_pkg::T0A_BIT;
    nxt_tev[0] = !cfg_ff[1].dir[tb] & sync_ff[1][tb];
    nxt_tev[1] = !cfg_ff[3].dir[pinmux_pkg::T1_BIT] & sync_ff[3][pinmux_pkg::T1_BIT];
    tb = tloc_ff[pinmux_pkg::TLOC_T4B] ? pinmux_pkg::T4B_BIT : pinmux_pkg::T4A_BIT;
    nxt_tev[2] = !cfg_ff[1].dir[tb] & sync_ff[1][tb];
    nxt_tev[3] = !cfg_ff[3].dir[pinmux_pkg::T5_BIT] & sync_ff[3][pinmux_pkg::T5_BIT];
end

// peripheral-side inputs registered
always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
        rx_ff <= 3'b111;
        clk_ff <= 3'b111;
        urx_ff <= 2'b11;
        tev_ff <= 4'h0;
        i2c_data_ff <= 1'b1;
        i2c_clock_ff <= 1'b1;
    end else begin
        rx_ff <= nxt_rx;
        clk_ff <= nxt_clk;
        urx_ff <= nxt_urx;
        tev_ff <= nxt_tev;
        i2c_data_ff <= i2c_ff[pinmux_pkg::I2C_LOCB] ? sync_ff[2][pinmux_pkg::I2C_DB_BIT]
                                                    : sync_ff[0][pinmux_pkg::I2C_DA_BIT];
        i2c_clock_ff <= sync_ff[2][pinmux_pkg::I2C_CK_BIT];
    end
end

assign SER_RX_DATA_OUT = rx_ff;
assign SER_CLK_OUT = clk_ff;
assign UART_RX_DATA_OUT = urx_ff;
assign TIMER_EVENT_OUT = tev_ff;
assign I2C_DATA_OUT = i2c_data_ff;
assign I2C_CLOCK_OUT = i2c_clock_ff;

////////////////////////////////////////////////////////////////////////////////
// pin drivers

// unselected pins fall back to the port data latch
always_comb begin
    for (int p = 0; p < pinmux_pkg::PORTS; p++) begin
        drive[p] = (psel[p] & pval[p]) | (~psel[p] & cfg_ff[p].data);
    end
end

// open-drain releases the pin for a high; pull-up only on inputs
always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
        for (int p = 0; p < pinmux_pkg::PORTS; p++) begin
            out_ff[p] <= 8'h00;
            oe_ff[p] <= 8'h00;
            pull_ff[p] <= 8'h00;
        end
    end else begin
        for (int p = 0; p < pinmux_pkg::PORTS; p++) begin
            out_ff[p] <= drive[p] & ~cfg_ff[p].od;
            oe_ff[p] <= cfg_ff[p].dir & ~(cfg_ff[p].od & drive[p]);
            pull_ff[p] <= cfg_ff[p].pull & ~cfg_ff[p].dir;
        end
    end
end

assign PORT0_PIN_OUT = out_ff[0];
assign PORT1_PIN_OUT = out_ff[1];
assign PORT5_PIN_OUT = out_ff[2];
assign PORT7_PIN_OUT = out_ff[3];
assign PORT0_PIN_OE_OUT = oe_ff[0];
assign PORT1_PIN_OE_OUT = oe_ff[1];
assign PORT5_PIN_OE_OUT = oe_ff[2];
assign PORT7_PIN_OE_OUT = oe_ff[3];
assign PORT0_PULLUP_OUT = pull_ff[0];
assign PORT1_PULLUP_OUT = pull_ff[1];
assign PORT5_PULLUP_OUT = pull_ff[2];
assign PORT7_PULLUP_OUT = pull_ff[3];

////////////////////////////////////////////////////////////////////////////////
// assertions

property p_od_release;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    (cfg_ff[0].od != 8'h00)
    |=> ((PORT0_PIN_OUT & $past(cfg_ff[0].od)) == 8'h00)
        && ((PORT0_PIN_OE_OUT & $past(cfg_ff[0].od & drive[0])) == 8'h00);
endproperty
a_od_release: assert property (p_od_release) else $error("open-drain pin drove high");

property p_ser0_tx;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    (mode_ff[0][0] && !mode_ff[0][3] && !mode_ff[0][4] && cfg_ff[0].dir[3] && !cfg_ff[0].od[3])
    |=> PORT0_PIN_OE_OUT[3] && (PORT0_PIN_OUT[3] == $past(SER_TX_DATA_IN[0]));
endproperty
a_ser0_tx: assert property (p_ser0_tx) else $error("serial 0 data missing on transmit pin");

property p_ser0_rx;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    (!mode_ff[0][1] || mode_ff[0][3]
        || (mode_ff[0][4] ? cfg_ff[3].dir[1] : cfg_ff[0].dir[4])) |=> SER_RX_DATA_OUT[0];
endproperty
a_ser0_rx: assert property (p_ser0_rx) else $error("serial 0 receive not held idle");

property p_ser3_clk_in;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    (mode_ff[2][0] && !cfg_ff[2].dir[2]) ##1 (mode_ff[2][0] && !cfg_ff[2].dir[2])
    |=> SER_CLK_OUT[2] == $past(PORT5_PIN_IN[2], 3);
endproperty
a_ser3_clk_in: assert property (p_ser3_clk_in) else $error("serial 3 clock input not passed");

property p_uart1_tx;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    (mode_ff[1][0] && mode_ff[1][3] && mode_ff[1][4] && cfg_ff[3].dir[3] && !cfg_ff[3].od[3])
    |=> PORT7_PIN_OUT[3] == $past(UART_TX_DATA_IN[1]);
endproperty
a_uart1_tx: assert property (p_uart1_tx) else $error("uart 1 data missing on pin");

property p_uart0_rx;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    (mode_ff[0][1] && mode_ff[0][3] && !mode_ff[0][4] && !cfg_ff[0].dir[4])
    |=> (UART_RX_DATA_OUT[0] == $past(sync_ff[0][4])) && SER_RX_DATA_OUT[0];
endproperty
a_uart0_rx: assert property (p_uart0_rx) else $error("uart 0 receive path wrong");

property p_timer5_event;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    cfg_ff[3].dir[7] |=> !TIMER_EVENT_OUT[3];
endproperty
a_timer5_event: assert property (p_timer5_event) else $error("event from output timer pin");

property p_timer4_out;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    (omd_ff[2] && cfg_ff[1].dir[2] && !cfg_ff[1].od[2]) |=> PORT1_PIN_OUT[2] == $past(TIMER_PULSE_IN[2]);
endproperty
a_timer4_out: assert property (p_timer4_out) else $error("timer 4 pulse missing");

property p_pull_input;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    cfg_ff[1].dir[0] |=> !PORT1_PULLUP_OUT[0];
endproperty
a_pull_input: assert property (p_pull_input) else $error("pull-up on an output pin");

property p_remote_out;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    (omd_ff[0] && rmt_ff[0] && cfg_ff[1].dir[0] && !cfg_ff[1].od[0])
    |=> PORT1_PIN_OUT[0] == $past(REMOTE_CARRIER_IN);
endproperty
a_remote_out: assert property (p_remote_out) else $error("remote carrier missing");

property p_gpio_port7;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    (mode_ff[0] == 8'h00 && mode_ff[1] == 8'h00)
    |=> PORT7_PIN_OUT == $past(cfg_ff[3].data & ~cfg_ff[3].od);
endproperty
a_gpio_port7: assert property (p_gpio_port7) else $error("idle port 7 not general purpose");

property p_ack_pulse;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    WB_ACK_OUT |=> !WB_ACK_OUT;
endproperty
a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

endmodule // serial_timer_pin_mux
`default_nettype wire

// >>> sim/pin_partner.sv
// off-chip devices and pull resistors seen by the four port pin groups
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    input wire logic clk_in,
    input wire logic [31:0] out_in,
    input wire logic [31:0] oe_in,
    input wire logic [31:0] pu_in,
    input wire logic [31:0] ext_en_in,
    input wire logic [31:0] ext_val_in,
    output logic [31:0] pin_out
);
    logic [31:0] float_ff = 32'h5555_5555;
    // a floating pin changes every cycle so a stale level is never trusted
    always_ff @(posedge clk_in) float_ff <= ~float_ff;
    // device drive wins, then the far side, then pull-up or float
    assign pin_out = (oe_in & out_in) | (~oe_in & ext_en_in & ext_val_in)
        | (~oe_in & ~ext_en_in & (pu_in | float_ff));
endmodule // pin_partner
`default_nettype wire

// >>> sim/tb_serial_timer_pin_mux.sv
// self-checking bench for the serial and timer pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb_serial_timer_pin_mux;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, rmc = 0, ida = 0, ick = 0;
    logic [7:0] adr = 8'h00, d;
    logic [31:0] wdat = 32'h0, ext_val = 32'h0, ext_en = 32'hff00_ffff;
    logic [2:0] stx = 3'h0, sclk = 3'h0;
    logic [1:0] utx = 2'h0;
    logic [3:0] tpl = 4'h0;
    wire [31:0] rdat, p_out, p_oe, p_pu, p_in;
    wire [2:0] srx, sck;
    wire [1:0] urx;
    wire [3:0] tev;
    wire ack, i2cd, i2cc;
    int err_count = 0, samples_checked = 0;
    logic [31:0] exp_q[$];
    ////////////////////////////////////////////////////////////////////////////////
    initial forever #5 clk = ~clk;
    serial_timer_pin_mux serial_timer_pin_mux_i (.REF_CLK_IN(clk), .RESET_IN(rst),
        .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
        .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
        .PORT0_PIN_IN(p_in[7:0]), .PORT1_PIN_IN(p_in[15:8]),
        .PORT5_PIN_IN(p_in[23:16]), .PORT7_PIN_IN(p_in[31:24]),
        .PORT0_PIN_OUT(p_out[7:0]), .PORT1_PIN_OUT(p_out[15:8]),
        .PORT5_PIN_OUT(p_out[23:16]), .PORT7_PIN_OUT(p_out[31:24]),
        .PORT0_PIN_OE_OUT(p_oe[7:0]), .PORT1_PIN_OE_OUT(p_oe[15:8]),
        .PORT5_PIN_OE_OUT(p_oe[23:16]), .PORT7_PIN_OE_OUT(p_oe[31:24]),
        .PORT0_PULLUP_OUT(p_pu[7:0]), .PORT1_PULLUP_OUT(p_pu[15:8]),
        .PORT5_PULLUP_OUT(p_pu[23:16]), .PORT7_PULLUP_OUT(p_pu[31:24]),
        .SER_TX_DATA_IN(stx), .SER_CLK_IN(sclk), .SER_RX_DATA_OUT(srx),
        .SER_CLK_OUT(sck), .UART_TX_DATA_IN(utx), .UART_RX_DATA_OUT(urx),
        .TIMER_PULSE_IN(tpl), .TIMER_EVENT_OUT(tev), .REMOTE_CARRIER_IN(rmc),
        .I2C_DATA_DRV_IN(ida), .I2C_CLOCK_DRV_IN(ick), .I2C_DATA_OUT(i2cd),
        .I2C_CLOCK_OUT(i2cc));
    pin_partner pin_partner_i (.clk_in(clk), .out_in(p_out), .oe_in(p_oe), .pu_in(p_pu),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_out(p_in));
    ////////////////////////////////////////////////////////////////////////////////
    // compare one value and count it
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // one classic wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, v};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) check(32'h0, 32'h1);
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        wb(1'b0, a, 8'h00);
    endtask
    // fresh random peripheral and far-side levels
    task automatic rnd;
        @(posedge clk);
        {stx, sclk, utx, tpl, rmc, ida, ick} <= 15'($urandom);
        ext_val <= $urandom;
    endtask
    // pin path is at most four edges; let it land
    task automatic st;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // read data is taken off the queue when the answer arrives
    always @(posedge clk)
        if (ack === 1'b1 && cyc && !we) check(rdat, exp_q.pop_front());
    initial begin
        #100000;
        err_count++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h355d));
        repeat (2) @(posedge clk);
        rst <= 0;
        d = 8'($urandom);
        rd(pinmux_pkg::ADR_OMD, 8'h00);
        rd(8'h7c, 8'h00);
        wb(1'b1, 8'h00, d);
        wb(1'b1, 8'h7c, 8'hff);
        rd(8'h00, d);
        rd(8'h7c, 8'h00);
        $display("register test done");
        wb(1'b1, 8'h04, 8'h08);
        rnd();
        st();
        check(p_out[3], d[3]);
        wb(1'b1, pinmux_pkg::ADR_SER0, 8'h01);
        rnd();
        st();
        check({p_oe[3], p_out[3]}, {1'b1, stx[0]});
        wb(1'b1, 8'h0c, 8'h08);
        rnd();
        st();
        check({p_oe[3], p_out[3]}, {!stx[0], 1'b0});
        wb(1'b1, 8'h0c, 8'h00);
        wb(1'b1, pinmux_pkg::ADR_SER0, 8'h09);
        rnd();
        st();
        check(p_out[3], utx[0]);
        $display("transmit test done");
        wb(1'b1, 8'h04, 8'h10);
        wb(1'b1, pinmux_pkg::ADR_SER0, 8'h02);
        st();
        check(srx[0], 1'b1);
        wb(1'b1, 8'h04, 8'h00);
        rnd();
        st();
        check(srx[0], ext_val[4]);
        wb(1'b1, pinmux_pkg::ADR_SER0, 8'h0a);
        rnd();
        st();
        check(urx[0], ext_val[4]);
        wb(1'b1, pinmux_pkg::ADR_SER0, 8'h01);
        rnd();
        st();
        check(sck[0], ext_val[5]);
        wb(1'b1, 8'h04, 8'h20);
        wb(1'b1, pinmux_pkg::ADR_SER0, 8'h05);
        rnd();
        st();
        check({p_oe[5], p_out[5]}, {1'b1, sclk[0]});
        $display("receive and clock test done");
        wb(1'b1, 8'h18, 8'h01);
        rnd();
        st();
        check({tev[0], p_pu[8]}, {ext_val[8], 1'b1});
        wb(1'b1, 8'h14, 8'h01);
        wb(1'b1, pinmux_pkg::ADR_OMD, 8'h01);
        rnd();
        st();
        check({tev[0], p_pu[8], p_out[8]}, {2'b00, tpl[0]});
        wb(1'b1, pinmux_pkg::ADR_RMT, 8'h01);
        rnd();
        st();
        check(p_out[8], rmc);
        wb(1'b1, pinmux_pkg::ADR_OMD, 8'h00);
        wb(1'b1, 8'h10, 8'h01);
        st();
        check(p_out[8], 1'b1);
        $display("timer and remote test done");
        wb(1'b1, pinmux_pkg::ADR_I2C, 8'h01);
        wb(1'b1, 8'h2c, 8'h10);
        wb(1'b1, 8'h24, 8'h10);
        repeat (3) begin
            rnd();
            st();
            check({p_oe[20], p_out[20]}, {!ick, 1'b0});
            if (!ick) check(i2cc, 1'b0);
        end
        $display("i2c test done");
        wb(1'b1, 8'h0c, 8'h02);
        wb(1'b1, 8'h04, 8'h22);
        wb(1'b1, 8'h34, 8'h08);
        wb(1'b1, pinmux_pkg::ADR_SER1, 8'h19);
        wb(1'b1, pinmux_pkg::ADR_SER3, 8'h01);
        wb(1'b1, pinmux_pkg::ADR_TLOC, 8'h01);
        wb(1'b1, 8'h08, 8'hff);
        wb(1'b1, 8'h28, 8'hfb);
        wb(1'b1, 8'h38, 8'hff);
        rnd();
        st();
        check({p_oe[27], p_out[27]}, {1'b1, utx[1]});
        check({p_oe[1], p_out[1], i2cd}, {!ida, 1'b0, ida & ext_val[1]});
        check(tev[0], ext_val[9]);
        check(p_pu, 32'hf7eb_00dd);
        $display("location and pull test done");
        print_verdict();
    end
endmodule // tb_serial_timer_pin_mux
`default_nettype wire
